// file: logic/sef_front.sv
`timescale 1ns/1ns
// How it works
// [R1] Modes 0 and 3 both work: only sampled clock edges matter.
// [R2] Inputs taken on rising clock edges, outputs changed on falling edges.
// [R3] Bytes travel MSB first both ways; the instruction is the first byte.
// [R4] A command starts on chip select falling; first rising edge takes bit 7.
// [R5] Output starts on the first falling edge after the instruction byte.
// [R6] Standby while deselected and no write cycle runs; active when selected.
// [R7] Reset clears state; commands are ignored until the settling time ends.
// [R8] Brown-out input resets state, latch and settling like power-up; the receive buffer keeps its words.
// [R9] Pause only stops the serial side; write cycles keep running.
// [R10] Pause starts when hold is low during clock low, else at next low.
// [R11] While paused output is off and clock and data are ignored.
// [R12] Pause ends when hold is high during clock low, else at next low.
// [R13] Deselecting while paused, or any time, abandons the command.
// [R14] Unknown opcodes send the block to a wait state until deselected.
// [R15] Decode 06h set latch, 04h clear latch, 05h status read.
// [R16] Decode 01h status write, 03h array read, 02h array write.
// [R17] Decode 83h id read, 82h id write, 81h serial number read.
// [R18] Status: guard bit 7, zeros 6:4, block guard 3:2, latch 1, busy 0.
// [R19] Block guard selects none, upper quarter, upper half or whole array.
// [R20] Busy mirrors the write cycle; latch reads 0 after power-up.
// [R21] Status read repeats the status byte until chip select rises.
// [R22] Status reads are accepted even while a write cycle runs.
// [R23] Only 06h sets the latch; then the block waits for deselect.
// [R24] Latch clears at reset, on 04h, and when a write completes.
// [R25] Output is off while chip select is high.
// [R26] Opcode decoded on the eighth rising edge; redecode needs a new select.

////////////////////////////////////////////////////////////////////////////////
module sef_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s f_reg;
  fifo_s f_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // full and empty come straight from the word count
  assign in_ready = f_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = f_reg.cnt != '0;
  assign out_data = mem[f_reg.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.wr = (f_reg.wr == AW'(DEPTH - 1)) ? '0 : f_reg.wr + 1'b1;
    end
    if (pop) begin
      f_next.rd = (f_reg.rd == AW'(DEPTH - 1)) ? '0 : f_reg.rd + 1'b1;
    end
    f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // storage has no reset; words are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[f_reg.wr] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sef_front
  import sef_pkg::*;
#(
  parameter int INIT_WAIT = INIT_CYCLES
) (
  // clock and power-on reset
  input wire logic MCLK,
  input wire logic RST,
  // serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SDI,
  input wire logic HOLD_N,
  output logic SDO,
  output logic SDO_OE,
  // supply monitor
  input wire logic BROWNOUT,
  // write-cycle engine and stored bits
  input wire logic WRITE_BUSY,
  input wire logic WRITE_DONE,
  input wire sef_nv_s NV_BITS,
  // state seen by the rest of the device
  output logic [7:0] STATUS_OUT,
  output logic STANDBY,
  output logic PAUSED,
  output logic WAITING,
  output logic PROT_ON,
  output logic [15:0] PROT_BASE,
  output logic OVERRUN,
  // received command bytes
  output logic CMD_VALID,
  input wire logic CMD_READY,
  output sef_rec_s CMD_DATA
);
  localparam logic [23:0] INIT_LAST = 24'(INIT_WAIT - 1);
  sef_core_s c_reg;
  sef_core_s c_next;
  logic cs_n;
  logic sck;
  logic rise;
  logic fall;
  logic cs_fall;
  logic [7:0] byte_in;
  logic [7:0] stat_word;
  logic set_cmd;
  logic clr_cmd;
  logic bad_cmd;
  logic push;
  logic fifo_ready;
  sef_rec_s rec;

  // status word assembled from live inputs and the latch
  function automatic logic [7:0] status_of(sef_nv_s nv, logic latch,
                                            logic busy);
    logic [7:0] w;
    w = '0;
    w[ST_GUARD_BIT] = nv.guard;
    w[6:4] = ST_RESERVED_VAL; // see [R18]
    w[ST_BLOCK_HI:ST_BLOCK_LO] = nv.block;
    w[ST_LATCH_BIT] = latch;
    w[ST_BUSY_BIT] = busy; // see [R20]
    return w;
  endfunction
  function automatic logic known_op(logic [7:0] op);
    return op == OP_STATUS_WR || op == OP_ARRAY_RD // see [R16]
        || op == OP_ARRAY_WR || op == OP_IDPAGE_RD // see [R17]
        || op == OP_IDPAGE_WR || op == OP_SERIAL_RD;
  endfunction
  // synchronised pins and edges, edges ignored while paused
  assign cs_n = c_reg.cs_sy[1];
  assign sck = c_reg.sck_sy[1];
  assign rise = sck & ~c_reg.sck_d & ~c_reg.paused; // see [R2] [R11]
  assign fall = ~sck & c_reg.sck_d & ~c_reg.paused; // see [R1]
  assign cs_fall = ~cs_n & c_reg.cs_d; // see [R4]
  assign byte_in = {c_reg.in_sh[6:0], c_reg.sdi_sy[1]}; // see [R3]
  assign stat_word = status_of(NV_BITS, c_reg.latch, WRITE_BUSY); // see [R22]

  // opcode events on the eighth rising edge
  assign set_cmd = rise && c_reg.st == ST_OPCODE && c_reg.bit_cnt == BIT_LAST
                   && byte_in == OP_SET_LATCH; // see [R15]
  assign clr_cmd = rise && c_reg.st == ST_OPCODE && c_reg.bit_cnt == BIT_LAST
                   && byte_in == OP_CLR_LATCH;
  assign bad_cmd = rise && c_reg.st == ST_OPCODE && c_reg.bit_cnt == BIT_LAST
                   && !known_op(byte_in) && byte_in != OP_SET_LATCH
                   && byte_in != OP_CLR_LATCH && byte_in != OP_STATUS_RD;

  // main next-state logic
  always_comb begin
    c_next = c_reg;
    push = 1'b0;
    rec = '{opcode: c_reg.opcode, data: byte_in};
    c_next.cs_sy = {c_reg.cs_sy[0], CS_N};
    c_next.sck_sy = {c_reg.sck_sy[0], SCK};
    c_next.sdi_sy = {c_reg.sdi_sy[0], SDI};
    c_next.hold_sy = {c_reg.hold_sy[0], HOLD_N};
    c_next.bor_sy = {c_reg.bor_sy[0], BROWNOUT};
    c_next.sck_d = sck;
    c_next.cs_d = cs_n;
    // settling time after reset before commands are honoured
    if (!c_reg.init_done) begin
      if (c_reg.init_cnt == INIT_LAST) begin
        c_next.init_done = 1'b1; // see [R7]
      end else begin
        c_next.init_cnt = c_reg.init_cnt + 24'h1;
      end
    end
    // hold only changes state while the clock is low
    if (cs_n) begin
      c_next.paused = 1'b0;
    end else if (!sck) begin
      c_next.paused = ~c_reg.hold_sy[1]; // see [R10] [R12]
    end
    if (cs_n) begin
      c_next.st = ST_STANDBY; // see [R13] [R21]
      c_next.bit_cnt = BIT_FIRST;
      c_next.drv = 1'b0;
    end else begin
      case (c_reg.st)
        ST_STANDBY: begin
          if (cs_fall) begin
            c_next.st = c_reg.init_done ? ST_OPCODE : ST_WAIT; // see [R7]
            c_next.bit_cnt = BIT_FIRST;
          end
        end
        ST_OPCODE: begin
          if (rise) begin
            c_next.in_sh = byte_in;
            c_next.bit_cnt = c_reg.bit_cnt + 3'h1;
            if (c_reg.bit_cnt == BIT_LAST) begin
              c_next.opcode = byte_in; // see [R26]
              if (byte_in == OP_STATUS_RD) begin
                c_next.st = ST_STATUS;
              end else if (known_op(byte_in)) begin
                c_next.st = ST_DATA;
              end else begin
                c_next.st = ST_WAIT; // see [R14] [R23]
              end
            end
          end
        end
        ST_STATUS: begin
          // the status byte reloads every eighth falling edge
          if (fall) begin
            c_next.drv = 1'b1; // see [R5]
            if (c_reg.out_cnt == BIT_FIRST) begin
              c_next.sdo = stat_word[7];
              c_next.out_sh = stat_word[6:0]; // see [R21]
              c_next.out_cnt = BIT_LAST;
            end else begin
              c_next.sdo = c_reg.out_sh[6]; // see [R3]
              c_next.out_sh = {c_reg.out_sh[5:0], 1'b0};
              c_next.out_cnt = c_reg.out_cnt - 3'h1;
            end
          end
        end
        ST_DATA: begin
          // a byte that finds the buffer full is lost and flagged
          if (rise) begin
            c_next.in_sh = byte_in;
            c_next.bit_cnt = c_reg.bit_cnt + 3'h1;
            if (c_reg.bit_cnt == BIT_LAST) begin
              push = 1'b1;
              if (!fifo_ready) begin
                c_next.overrun = 1'b1;
              end
            end
          end
        end
        ST_WAIT: c_next.st = ST_WAIT;
        default: c_next.st = ST_STANDBY;
      endcase
    end
    if (c_next.st != ST_STATUS) begin
      c_next.out_cnt = BIT_FIRST;
    end
    // set wins over a write completion in the same cycle
    c_next.latch = set_cmd
                   | (c_reg.latch & ~clr_cmd & ~WRITE_DONE); // see [R24]
    // brown-out restarts settling and clears state, latch and overrun
    if (c_reg.bor_sy[1]) begin
      c_next.st = ST_STANDBY; // see [R8]
      c_next.latch = ST_LATCH_RESET;
      c_next.drv = 1'b0;
      c_next.init_done = 1'b0;
      c_next.init_cnt = '0;
      c_next.overrun = 1'b0;
      push = 1'b0;
    end
    c_next.oe = c_next.drv & ~c_next.paused & ~cs_n; // see [R11] [R25]
    c_next.standby = cs_n & ~WRITE_BUSY; // see [R6] [R9]
    c_next.status = status_of(NV_BITS, c_next.latch, WRITE_BUSY);
    c_next.prot_on = NV_BITS.block != GUARD_NONE; // see [R19]
    if (NV_BITS.block == GUARD_QUARTER) begin
      c_next.prot_base = BASE_QUARTER;
    end else if (NV_BITS.block == GUARD_HALF) begin
      c_next.prot_base = BASE_HALF;
    end else begin
      c_next.prot_base = BASE_WHOLE;
    end
  end

  // select and hold idle high so reset values match a deselected bus
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      c_reg <= '{cs_sy: 2'h3, sck_sy: 2'h0, sdi_sy: 2'h0, hold_sy: 2'h3,
                 bor_sy: 2'h0, sck_d: 1'b0, cs_d: 1'b1, st: ST_STANDBY,
                 latch: ST_LATCH_RESET, standby: 1'b1, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  // receive buffer toward the array and status write paths
  sef_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rec),
    .out_valid(CMD_VALID),
    .out_ready(CMD_READY),
    .out_data(CMD_DATA)
  );

  // outputs from flops
  assign SDO = c_reg.sdo;
  assign SDO_OE = c_reg.oe;
  assign STATUS_OUT = c_reg.status;
  assign STANDBY = c_reg.standby;
  assign PAUSED = c_reg.paused;
  assign WAITING = c_reg.st == ST_WAIT;
  assign PROT_ON = c_reg.prot_on;
  assign PROT_BASE = c_reg.prot_base;
  assign OVERRUN = c_reg.overrun;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_oe_deselect: assert property (cs_n |=> !SDO_OE) // see [R25]
    else $error("output enabled while deselected");
  a_oe_paused: assert property (PAUSED |-> !SDO_OE) // see [R11]
    else $error("output enabled while paused");
  a_set_latch: assert property (set_cmd && !c_reg.bor_sy[1]
      |=> STATUS_OUT[ST_LATCH_BIT]) // see [R23]
    else $error("set latch opcode did not set latch");
  a_clear_latch: assert property ((clr_cmd || WRITE_DONE) && !set_cmd
      |=> !STATUS_OUT[ST_LATCH_BIT]) // see [R24]
    else $error("latch not cleared");
  a_bad_opcode: assert property (bad_cmd && !c_reg.bor_sy[1]
      |=> WAITING) // see [R14]
    else $error("unknown opcode not sent to wait");
  a_reserved_zero: assert property (STATUS_OUT[6:4] == 3'h0) // see [R18]
    else $error("reserved status bits not zero");
  a_first_bit: assert property (fall && c_reg.st == ST_STATUS && !cs_n
      && c_reg.out_cnt == BIT_FIRST && !c_reg.bor_sy[1]
      |=> SDO == $past(stat_word[7])) // see [R21]
    else $error("status byte not started with bit 7");
  a_pause_start: assert property (!cs_n && !sck && !c_reg.hold_sy[1]
      |=> PAUSED) // see [R10]
    else $error("pause did not start in clock low");
  a_standby_lvl: assert property (STANDBY
      == ($past(cs_n) && !$past(WRITE_BUSY))) // see [R6]
    else $error("standby level wrong");
  a_init_ignore: assert property (cs_fall && c_reg.st == ST_STANDBY
      && !c_reg.init_done && !c_reg.bor_sy[1] |=> WAITING) // see [R7]
    else $error("command taken before settling");

  c_status_read: cover property (c_reg.st == ST_STATUS ##1 SDO_OE);
  c_set_latch: cover property (set_cmd);
  c_pause: cover property (PAUSED && c_reg.st == ST_OPCODE);
  c_bad_op: cover property (bad_cmd);
endmodule

// file: logic/sef_pkg.sv
package sef_pkg;

  // sampling clock and power-up settling time
  localparam int CLK_MHZ = 100;
  localparam int T_INIT_US = 100;
  localparam int INIT_CYCLES = T_INIT_US * CLK_MHZ;

  // instruction codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_ARRAY_RD = 8'h03;
  localparam logic [7:0] OP_ARRAY_WR = 8'h02;
  localparam logic [7:0] OP_IDPAGE_RD = 8'h83;
  localparam logic [7:0] OP_IDPAGE_WR = 8'h82;
  localparam logic [7:0] OP_SERIAL_RD = 8'h81;

  // status word layout
  localparam int ST_GUARD_BIT = 7;
  localparam int ST_BLOCK_HI = 3;
  localparam int ST_BLOCK_LO = 2;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam logic [2:0] ST_RESERVED_VAL = 3'h0;
  localparam logic ST_LATCH_RESET = 1'h0;

  // bit counting within a byte
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // block-guard protected region start addresses
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [15:0] BASE_QUARTER = 16'hC000;
  localparam logic [15:0] BASE_HALF = 16'h8000;
  localparam logic [15:0] BASE_WHOLE = 16'h0000;

  // receive buffer shape
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_OPCODE = 5'h02,
    ST_STATUS = 5'h04,
    ST_DATA = 5'h08,
    ST_WAIT = 5'h10
  } sef_state_e;

  // non-volatile protection bits held outside this block
  typedef struct packed {
    logic guard;
    logic [1:0] block;
  } sef_nv_s;

  // one received byte with the instruction it belongs to
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
  } sef_rec_s;

  typedef struct packed {
    logic [1:0] cs_sy;
    logic [1:0] sck_sy;
    logic [1:0] sdi_sy;
    logic [1:0] hold_sy;
    logic [1:0] bor_sy;
    logic sck_d;
    logic cs_d;
    logic paused;
    sef_state_e st;
    logic [2:0] bit_cnt;
    logic [7:0] in_sh;
    logic [7:0] opcode;
    logic latch;
    logic drv;
    logic [2:0] out_cnt;
    logic [6:0] out_sh;
    logic sdo;
    logic oe;
    logic standby;
    logic overrun;
    logic [7:0] status;
    logic prot_on;
    logic [15:0] prot_base;
    logic [23:0] init_cnt;
    logic init_done;
  } sef_core_s;

endpackage

// file: sim/sef_master.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// bus master model, pins move only on falling MCLK edges
module sef_master (
  // pacing clock
  input wire logic MCLK,
  // serial pins
  output logic CS_N,
  output logic SCK,
  output logic SDI,
  output logic HOLD_N,
  input wire logic SDO
);
  logic mode3; // clock idle level, 0 for mode 0 and 1 for mode 3

  // idle pins at time zero, select kept high as by a pull-up
  initial begin
    mode3 = 1'h0;
    CS_N = 1'h1;
    SCK = 1'h0;
    SDI = 1'h0;
    HOLD_N = 1'h1;
  end

  // pacing in MCLK falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  // idle level first, then a select fall to open the command
  task automatic sel();
    SCK = mode3;
    wt(4);
    CS_N = 1'h0;
    wt(4);
  endtask

  // one byte, data set with the clock low and taken on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SCK = 1'h0;
      SDI = tx[i];
      wt(4);
      rx[i] = SDO;
      SCK = 1'h1;
      wt(4);
    end
  endtask

  // deselect; the released data line wanders so stale bits never help
  task automatic desel();
    SCK = mode3;
    wt(4);
    CS_N = 1'h1;
    SDI = ~SDI;
    wt(6);
  endtask

  // single pin moves around a pause; data wanders with the clock
  task automatic set_sck(input logic lvl);
    SCK = lvl;
    SDI = ~SDI;
    wt(5);
  endtask

  task automatic set_hold(input logic lvl);
    HOLD_N = lvl;
    wt(5);
  endtask
endmodule

// file: sim/test_sef_front.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module test_sef_front
  import sef_pkg::*;
;
  localparam int INIT_SIM = 20; // short settling count keeps the run brief
  logic mclk = 1'h0;
  logic rst, cs_n, sck, sdi, hold_n, sdo, sdo_oe, brownout;
  logic wr_busy, wr_done, standby, paused, waiting, prot_on, overrun;
  logic cmd_valid, cmd_ready, latch;
  logic [7:0] status, rx;
  logic [15:0] prot_base;
  logic sdo_line;
  sef_nv_s nv;
  sef_rec_s cmd_data;
  int miscompares = 0;
  int n_checks = 0;

  // 100 MHz system clock
  always #5 mclk = ~mclk;

  sef_front #(.INIT_WAIT(INIT_SIM)) DUT (
    .MCLK(mclk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SDI(sdi),
    .HOLD_N(hold_n), .SDO(sdo), .SDO_OE(sdo_oe), .BROWNOUT(brownout),
    .WRITE_BUSY(wr_busy), .WRITE_DONE(wr_done), .NV_BITS(nv),
    .STATUS_OUT(status), .STANDBY(standby), .PAUSED(paused),
    .WAITING(waiting), .PROT_ON(prot_on), .PROT_BASE(prot_base),
    .OVERRUN(overrun), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_DATA(cmd_data)
  );

  sef_master mst (
    .MCLK(mclk), .CS_N(cs_n), .SCK(sck), .SDI(sdi), .HOLD_N(hold_n),
    .SDO(sdo_line)
  );

  // a released data line reads inverted so stale bits never pass
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare and helpers
  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // status word as the bench expects it from its own copies
  function automatic logic [15:0] st_exp();
    return {8'h00, nv.guard, 3'h0, nv.block, latch, wr_busy};
  endfunction

  // status read with two repeats, then deselect
  task automatic rd_st();
    mst.sel();
    mst.xfer(OP_STATUS_RD, rx);
    repeat (2) begin
      mst.xfer(8'h00, rx);
      chk(16'(rx), st_exp());
    end
    chk(16'(status), st_exp());
    chk(16'(sdo_oe), 16'h1);
    mst.desel();
    chk(16'(sdo_oe), 16'h0);
  endtask

  task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] d);
    mst.sel();
    mst.xfer(op, rx);
    for (int k = 0; k < n; k++) mst.xfer(d + 8'(k), rx);
    mst.desel();
  endtask

  // drain one record, waiting a bounded time for it
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (cmd_valid !== 1'h1 && n < 20) begin
      wt(1);
      n++;
    end
    chk(16'(cmd_valid), 16'h1);
    cmd_ready = 1'h1;
    chk(cmd_data, exp);
    wt(1);
    cmd_ready = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_early();
    chk(16'({standby, paused, waiting, sdo_oe, overrun, cmd_valid}),
        16'h20);
    chk(16'(status), 16'h0);
    mst.sel();
    mst.xfer(OP_STATUS_RD, rx);
    mst.xfer(8'h00, rx);
    chk(16'({waiting, sdo_oe}), 16'h2);
    mst.desel();
  endtask

  // every guard code, both modes, with and without a write cycle
  task automatic t_prot();
    for (int b = 0; b < 4; b++) begin
      nv.guard = b[0];
      nv.block = 2'(b);
      wr_busy = b[1];
      mst.mode3 = b[0];
      wt(4);
      chk(16'(prot_on), 16'(b != 0));
      chk(prot_base, b == 1 ? 16'hC000 : b == 2 ? 16'h8000 : 16'h0);
      chk(16'(standby), 16'(!b[1]));
      rd_st();
    end
    wr_busy = 1'h0;
    mst.mode3 = 1'h0;
  endtask

  task automatic t_latch();
    mst.sel();
    chk(16'(standby), 16'h0);
    mst.xfer(OP_SET_LATCH, rx);
    mst.xfer(OP_STATUS_RD, rx);
    chk(16'({waiting, sdo_oe}), 16'h2);
    mst.desel();
    latch = 1'h1;
    rd_st();
    cmd(OP_CLR_LATCH, 0, 8'h00);
    latch = 1'h0;
    rd_st();
    cmd(OP_SET_LATCH, 0, 8'h00);
    wr_done = 1'h1;
    wt(1);
    wr_done = 1'h0;
    rd_st();
  endtask

  task automatic t_bad();
    mst.sel();
    mst.xfer(8'hFF, rx);
    mst.xfer(OP_STATUS_RD, rx);
    mst.xfer(8'h00, rx);
    chk(16'({waiting, sdo_oe, cmd_valid}), 16'h4);
    mst.desel();
    chk(16'(waiting), 16'h0);
  endtask

  // data opcodes forward bytes; a full buffer drops the ninth one
  task automatic t_rec();
    logic [7:0] ops [6];
    ops = '{OP_STATUS_WR, OP_ARRAY_RD, OP_ARRAY_WR,
            OP_IDPAGE_RD, OP_IDPAGE_WR, OP_SERIAL_RD};
    for (int i = 0; i < 6; i++) begin
      cmd(ops[i], 1, OP_STATUS_RD);
      pop({ops[i], OP_STATUS_RD});
    end
    cmd(OP_ARRAY_WR, FIFO_DEPTH + 1, 8'h10);
    chk(16'(overrun), 16'h1);
    for (int k = 0; k < FIFO_DEPTH; k++)
      pop({OP_ARRAY_WR, 8'h10 + 8'(k)});
    chk(16'(cmd_valid), 16'h0);
  endtask

  task automatic t_hold();
    mst.sel();
    mst.xfer(OP_STATUS_RD, rx);
    mst.xfer(8'h00, rx);
    mst.set_sck(1'h0);
    mst.set_hold(1'h0);
    chk(16'({paused, sdo_oe}), 16'h2);
    repeat (3) begin
      mst.set_sck(1'h1);
      mst.set_sck(1'h0);
    end
    chk(16'({paused, sdo_oe}), 16'h2);
    mst.set_hold(1'h1);
    chk(16'({paused, sdo_oe}), 16'h1);
    mst.xfer(8'h00, rx);
    chk(16'(rx), st_exp());
    mst.set_hold(1'h0);
    chk(16'(paused), 16'h0);
    mst.set_sck(1'h0);
    chk(16'(paused), 16'h1);
    mst.set_sck(1'h1);
    mst.set_hold(1'h1);
    chk(16'(paused), 16'h1);
    mst.set_sck(1'h0);
    chk(16'(paused), 16'h0);
    mst.set_hold(1'h0);
    chk(16'({paused, sdo_oe}), 16'h2);
    mst.desel();
    mst.set_hold(1'h1);
    chk(16'({standby, waiting}), 16'h2);
    rd_st();
  endtask

  task automatic t_brown();
    cmd(OP_SET_LATCH, 0, 8'h00);
    brownout = 1'h1;
    wt(4);
    brownout = 1'h0;
    wt(INIT_SIM + 10);
    latch = 1'h0;
    chk(16'(overrun), 16'h0);
    rd_st();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: four cycles of reset, then the scenarios
  initial begin
    rst = 1'h1;
    brownout = 1'h0;
    wr_busy = 1'h0;
    wr_done = 1'h0;
    nv = '0;
    cmd_ready = 1'h0;
    latch = 1'h0;
    wt(4);
    rst = 1'h0;
    t_early();
    wt(INIT_SIM);
    t_prot();
    t_latch();
    t_bad();
    t_rec();
    t_hold();
    t_brown();
    end_of_test();
  end

  // watchdog, several times the expected run length
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
endmodule
